// ==== rtl/irq_ctrl_pkg.sv ====
// constants, types and decode helpers shared by the interrupt request controller
// Behaviour
// - pin edge field: off, rise, fall, both
// - bits 3-2 pick receive-detect edges, same coding
// - edge bits 7-4 read zero; reset disabled
// - ctrl0 holds global, pin, rx, lv bits
// - ctrl1: converter, eeprom, timer0 enables and flags
// - ctrl2: time bases, timer1 enables and flags
// - pin plus ten internal request sources accepted
// - each source own enable and flag
// - events always set flags; jump needs both enables
// - acceptance clears global enable and serviced flag
// - no acknowledge while return stack full
// - newly set flag raises wake request
`default_nettype none
package irq_ctrl_pkg;

    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int REG_W   = 8;
    localparam int NUM_SRC = 11;
    localparam int VEC_W   = 4;
    localparam int STAT_W  = 2;

    // source index; lower index wins
    localparam int SRC_PIN  = 0;
    localparam int SRC_RX   = 1;
    localparam int SRC_LV   = 2;
    localparam int SRC_C1   = 3;
    localparam int SRC_C2   = 7;
    localparam int C0_SRCS  = 3;
    localparam int NIB      = 4;

    // register field positions
    localparam int C0_GIE_BIT   = 0;
    localparam int C0_EN_LSB    = 1;
    localparam int EN_LSB       = 0;
    localparam int FLAG_LSB     = 4;
    localparam int EDGE_W       = 4;
    localparam int EDGE_FIELD_W = 2;
    localparam int EDGE_PIN_LSB = 0;
    localparam int EDGE_RX_LSB  = 2;
    localparam int STAT_GRANT   = 0;
    localparam int STAT_WAKE    = 1;

    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] WARM_DONE = 2'h3;

    localparam logic [EDGE_W-1:0] EDGE_RST = 4'h0;

    localparam logic [ADDR_W-1:0] ADDR_EDGE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_C0   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_C1   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_C2   = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h14;

    typedef enum logic [2:0] {SEL_NONE, SEL_EDGE, SEL_C0, SEL_C1, SEL_C2, SEL_STAT,
                              SEL_MASK} reg_sel_e;
    typedef enum logic {APB_IDLE, APB_DONE} apb_state_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_s;

    function automatic reg_sel_e decodeAddr(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_EDGE: decodeAddr = SEL_EDGE;
            ADDR_C0:   decodeAddr = SEL_C0;
            ADDR_C1:   decodeAddr = SEL_C1;
            ADDR_C2:   decodeAddr = SEL_C2;
            ADDR_STAT: decodeAddr = SEL_STAT;
            ADDR_MASK: decodeAddr = SEL_MASK;
            default:   decodeAddr = SEL_NONE;
        endcase
    endfunction

endpackage
`default_nettype wire

// ==== rtl/edge_detect.sv ====
// synchronised line sampler with selectable edge detection
`default_nettype none
module edge_detect
    import irq_ctrl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       lineAsync,
    input  wire logic [1:0] edgeMode,
    output logic            edgeSeen,
    output logic            level
);

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       prev;
        logic [1:0] warm;
    } edge_state_s;

    edge_state_s cur;
    edge_state_s nxt;
    logic        rise;
    logic        fall;

    always_comb begin
        nxt      = cur;
        nxt.s1   = lineAsync;
        nxt.s2   = cur.s1;
        nxt.prev = cur.s2;
        nxt.warm = (cur.warm == WARM_DONE) ? cur.warm : 2'(cur.warm + 2'h1);
        rise     = cur.s2 & ~cur.prev;
        fall     = ~cur.s2 & cur.prev;
        case (edgeMode)
            EDGE_OFF:  edgeSeen = 1'b0;
            EDGE_RISE: edgeSeen = rise;
            EDGE_FALL: edgeSeen = fall;
            EDGE_BOTH: edgeSeen = rise | fall;
            default:   edgeSeen = 1'b0;
        endcase
        // ignore the startup transition until prev holds a real sample
        if (cur.warm != WARM_DONE) begin
            edgeSeen = 1'b0;
        end
    end

    assign level = cur.s2;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/prio_pick.sv ====
// fixed priority picker: lowest pending index wins
`default_nettype none
module prio_pick
    import irq_ctrl_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input  wire logic [N-1:0]     pending,
    output logic                  found,
    output logic [VEC_W-1:0]      index
);

    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                found = 1'b1;
                index = VEC_W'(i);
            end
        end
    end

endmodule
`default_nettype wire

// ==== rtl/interrupt_request_controller.sv ====
// interrupt request controller: apb registers, flags, priority grant, wake
`default_nettype none
module interrupt_request_controller
    import irq_ctrl_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire apb_req_s          apbReq,
    output apb_rsp_s               apbRsp,
    input  wire logic              extIrqPin,
    input  wire logic              receiveDetectLine,
    input  wire logic              lowVoltageEvt,
    input  wire logic              converterEvt,
    input  wire logic              eepromEvt,
    input  wire logic [1:0]        timerPMatchEvt,
    input  wire logic [1:0]        timerAMatchEvt,
    input  wire logic [1:0]        timeBaseEvt,
    input  wire logic              stackFull,
    input  wire logic              irqAck,
    output logic                   irqReq,
    output logic [VEC_W-1:0]       irqVector,
    output logic                   wakeReq,
    output logic                   receivePollInput,
    output logic                   irqOut
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        apb_state_e          apbSt;
        apb_rsp_s            rsp;
        logic [EDGE_W-1:0]   edgeSel;
        logic                gie;
        logic [NUM_SRC-1:0]  en;
        logic [NUM_SRC-1:0]  flags;
        logic [STAT_W-1:0]   mask;
        logic [STAT_W-1:0]   status;
        logic                irqReq;
        logic [VEC_W-1:0]    irqVec;
        logic                wake;
        logic                irqOut;
    } state_s;

    localparam state_s RST_STATE = '{
        apbSt:   APB_IDLE,
        rsp:     '0,
        edgeSel: EDGE_RST,
        gie:     1'b0,
        en:      '0,
        flags:   '0,
        mask:    '0,
        status:  '0,
        irqReq:  1'b0,
        irqVec:  '0,
        wake:    1'b0,
        irqOut:  1'b0
    };

    state_s               cur;
    state_s               nxt;
    logic                 pinEdge;
    logic                 rxEdge;
    logic                 rxLevel;
    logic [NUM_SRC-1:0]   evt;
    logic [NUM_SRC-1:0]   pending;
    logic [NUM_SRC-1:0]   flagBase;
    logic                 pickFound;
    logic [VEC_W-1:0]     pickIdx;
    logic                 access;
    logic                 done;
    logic                 wr;
    logic                 ackTake;
    logic                 wakeEvt;
    logic                 heldLive;
    reg_sel_e             sel;
    logic [REG_W-1:0]     rdReg;
    logic [DATA_W-1:0]    rdVal;
    logic [STAT_W-1:0]    statSet;
    logic [STAT_W-1:0]    statClr;
    logic [DATA_W-1:0]    wdata;

    function automatic logic [REG_W-1:0] packCtrl(input logic [NIB-1:0] f,
                                                  input logic [NIB-1:0] e);
        packCtrl = {f, e};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // line samplers

    edge_detect u_pin_edge (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .lineAsync (extIrqPin),
        .edgeMode  (cur.edgeSel[EDGE_PIN_LSB +: EDGE_FIELD_W]),
        .edgeSeen  (pinEdge),
        .level     ()
    );

    edge_detect u_rx_edge (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .lineAsync (receiveDetectLine),
        .edgeMode  (cur.edgeSel[EDGE_RX_LSB +: EDGE_FIELD_W]),
        .edgeSeen  (rxEdge),
        .level     (rxLevel)
    );

    // same clock sources, lowest priority first
    assign evt = {timerAMatchEvt[1], timerPMatchEvt[1], timeBaseEvt[1], timeBaseEvt[0],
                  timerAMatchEvt[0], timerPMatchEvt[0], eepromEvt, converterEvt,
                  lowVoltageEvt, rxEdge, pinEdge};

    assign pending = cur.flags & cur.en & {NUM_SRC{cur.gie}};

    prio_pick #(
        .N (NUM_SRC)
    ) u_pick (
        .pending (pending),
        .found   (pickFound),
        .index   (pickIdx)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register read mux

    assign sel = decodeAddr(apbReq.paddr);

    always_comb begin
        rdReg = '0;
        case (sel)
            SEL_EDGE: rdReg = {{(REG_W-EDGE_W){1'b0}}, cur.edgeSel};
            SEL_C0:   rdReg = packCtrl({1'b0, cur.flags[SRC_PIN +: C0_SRCS]},
                                       {cur.en[SRC_PIN +: C0_SRCS], cur.gie});
            SEL_C1:   rdReg = packCtrl(cur.flags[SRC_C1 +: NIB],
                                       cur.en[SRC_C1 +: NIB]);
            SEL_C2:   rdReg = packCtrl(cur.flags[SRC_C2 +: NIB],
                                       cur.en[SRC_C2 +: NIB]);
            SEL_STAT: rdReg = {{(REG_W-STAT_W){1'b0}}, cur.status};
            SEL_MASK: rdReg = {{(REG_W-STAT_W){1'b0}}, cur.mask};
            default:  rdReg = '0;
        endcase
        rdVal = {{(DATA_W-REG_W){1'b0}}, rdReg};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt      = cur;
        wdata    = apbReq.pwdata;
        access   = apbReq.psel & apbReq.penable;
        done     = access & (cur.apbSt == APB_DONE);
        wr       = done & apbReq.pwrite;
        ackTake  = irqAck & cur.irqReq;
        flagBase = cur.flags;
        statClr  = '0;

        // apb: one wait state, response registered
        case (cur.apbSt)
            APB_IDLE: begin
                nxt.rsp.pready  = 1'b0;
                nxt.rsp.pslverr = 1'b0;
                if (access) begin
                    nxt.apbSt       = APB_DONE;
                    nxt.rsp.pready  = 1'b1;
                    nxt.rsp.pslverr = (sel == SEL_NONE);
                    nxt.rsp.prdata  = apbReq.pwrite ? '0 : rdVal;
                end
            end
            APB_DONE: begin
                nxt.apbSt       = APB_IDLE;
                nxt.rsp.pready  = 1'b0;
                nxt.rsp.pslverr = 1'b0;
            end
            default: begin
                nxt.apbSt      = APB_IDLE;
                nxt.rsp.pready = 1'b0;
            end
        endcase

        // software writes to enables, flags and edge fields
        if (wr) begin
            case (sel)
                SEL_EDGE: nxt.edgeSel = wdata[EDGE_W-1:0];
                SEL_C0: begin
                    nxt.gie = wdata[C0_GIE_BIT];
                    nxt.en[SRC_PIN +: C0_SRCS]   = wdata[C0_EN_LSB +: C0_SRCS];
                    flagBase[SRC_PIN +: C0_SRCS] = wdata[FLAG_LSB +: C0_SRCS];
                end
                SEL_C1: begin
                    nxt.en[SRC_C1 +: NIB]   = wdata[EN_LSB +: NIB];
                    flagBase[SRC_C1 +: NIB] = wdata[FLAG_LSB +: NIB];
                end
                SEL_C2: begin
                    nxt.en[SRC_C2 +: NIB]   = wdata[EN_LSB +: NIB];
                    flagBase[SRC_C2 +: NIB] = wdata[FLAG_LSB +: NIB];
                end
                SEL_MASK: nxt.mask = wdata[STAT_W-1:0];
                default: begin
                end
            endcase
        end

        // core took the presented vector
        if (ackTake) begin
            flagBase[cur.irqVec] = 1'b0;
            nxt.gie = 1'b0;
        end

        // a source event beats any clear in the same cycle
        nxt.flags = flagBase | evt;
        wakeEvt   = |(evt & ~cur.flags);
        nxt.wake  = wakeEvt;

        // present the highest enabled request unless the stack is full
        // the vector stays put while its source waits; a withdrawn source drops the request
        heldLive   = pending[cur.irqVec];
        nxt.irqReq = pickFound & ~stackFull & ~ackTake
                     & ~(cur.irqReq & ~heldLive);
        if (pickFound && !(cur.irqReq && heldLive)) begin
            nxt.irqVec = pickIdx;
        end

        // sticky status, cleared by reading it; only bits reported are cleared
        statSet             = '0;
        statSet[STAT_GRANT] = ackTake;
        statSet[STAT_WAKE]  = wakeEvt;
        if (done && !apbReq.pwrite && sel == SEL_STAT) begin
            statClr = cur.rsp.prdata[STAT_W-1:0];
        end
        nxt.status = (cur.status & ~statClr) | statSet;
        nxt.irqOut = |(nxt.status & nxt.mask);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cur <= RST_STATE;
        end else begin
            cur <= nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign apbRsp           = cur.rsp;
    assign irqReq           = cur.irqReq;
    assign irqVector        = cur.irqVec;
    assign wakeReq          = cur.wake;
    assign receivePollInput = rxLevel;
    assign irqOut           = cur.irqOut;

endmodule
`default_nettype wire

// ==== tb/irq_ctrl_sva.sv ====
// concurrent checks on the interrupt request controller ports
`default_nettype none
module irq_ctrl_sva
    import irq_ctrl_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             rstn,
    input wire apb_req_s         apbReq,
    input wire apb_rsp_s         apbRsp,
    input wire logic             receiveDetectLine,
    input wire logic             stackFull,
    input wire logic             irqAck,
    input wire logic             irqReq,
    input wire logic [VEC_W-1:0] irqVector,
    input wire logic             receivePollInput,
    input wire logic             wakeReq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    a_stack_blocks_req: assert property (stackFull |=> !irqReq)
        else $error("request presented while stack full");
    a_ack_drops_req: assert property (irqReq && irqAck |=> !irqReq)
        else $error("request still up after grant");
    a_vector_held: assert property (irqReq && $past(irqReq) |-> $stable(irqVector))
        else $error("vector moved under a request");
    a_edge_top_zero: assert property (apbRsp.pready && !apbReq.pwrite
        && apbReq.paddr == ADDR_EDGE |-> apbRsp.prdata[31:4] == 28'h0)
        else $error("edge select upper bits not zero");
    a_ctrl0_top_zero: assert property (apbRsp.pready && !apbReq.pwrite
        && apbReq.paddr == ADDR_C0 |-> apbRsp.prdata[31:7] == 25'h0)
        else $error("ctrl0 bit 7 not zero");
    a_poll_follows: assert property (receivePollInput == $past(receiveDetectLine, 2))
        else $error("poll input does not follow the line");
    a_access_two: assert property (apbReq.psel && $rose(apbReq.penable) |=> apbRsp.pready)
        else $error("access phase not two cycles");
    a_pready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (apbRsp.pready |-> apbRsp.pslverr ==
        (apbReq.paddr > ADDR_MASK || apbReq.paddr[1:0] != 2'h0))
        else $error("error response wrong for address");
    c_grant: cover property (irqReq && irqAck);
    c_wake: cover property (wakeReq);
    c_err: cover property (apbRsp.pready && apbRsp.pslverr);
endmodule
bind interrupt_request_controller irq_ctrl_sva chk_u (.clk_sys(clk_sys), .rstn(rstn),
    .apbReq(apbReq), .apbRsp(apbRsp), .receiveDetectLine(receiveDetectLine),
    .stackFull(stackFull), .irqAck(irqAck), .irqReq(irqReq), .irqVector(irqVector),
    .receivePollInput(receivePollInput), .wakeReq(wakeReq));
`default_nettype wire

// ==== tb/core_model.sv ====
// processor core stand-in: grants requests after a lag, reports a full stack
`default_nettype none
module core_model
    import irq_ctrl_pkg::*;
#(
    parameter int LAG = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             irqReq,
    input  wire logic [VEC_W-1:0] irqVector,
    input  wire logic             fullReq,
    output logic                  irqAck,
    output logic                  stackFull
);
    timeunit 1ns;
    timeprecision 100ps;
    int               cnt;
    logic [VEC_W-1:0] seen[$];
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irqAck <= 1'b0;
            stackFull <= 1'b0;
            cnt <= 0;
        end else begin
            stackFull <= fullReq;
            irqAck <= 1'b0;
            cnt <= 0;
            if (irqReq && !irqAck && !stackFull) begin
                if (cnt >= LAG) begin
                    irqAck <= 1'b1;
                    seen.push_back(irqVector);
                end else begin
                    cnt <= cnt + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the interrupt request controller
`default_nettype none
module tb
    import irq_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic             clk_sys = 1'b0;
    logic             rstn = 1'b0;
    apb_req_s         apbReq = '0;
    apb_rsp_s         apbRsp;
    logic             extIrqPin = 1'b0;
    logic             rxLine = 1'b0;
    logic [8:0]       evt = '0;
    logic             fullReq = 1'b0;
    logic             stackFull, irqAck, irqReq, wakeReq, pollIn, irqOut;
    logic [VEC_W-1:0] irqVector;
    int               failures = 0;
    int               checksDone = 0;
    logic [31:0]      seed = 32'heb93;
    logic [31:0]      rd;
    logic             err;
    int               expVec[$];
    interrupt_request_controller dut_u (.clk_sys(clk_sys), .rstn(rstn), .apbReq(apbReq),
        .apbRsp(apbRsp), .extIrqPin(extIrqPin), .receiveDetectLine(rxLine),
        .lowVoltageEvt(evt[0]), .converterEvt(evt[1]), .eepromEvt(evt[2]),
        .timerPMatchEvt({evt[7], evt[3]}), .timerAMatchEvt({evt[8], evt[4]}),
        .timeBaseEvt(evt[6:5]), .stackFull(stackFull), .irqAck(irqAck), .irqReq(irqReq),
        .irqVector(irqVector), .wakeReq(wakeReq), .receivePollInput(pollIn), .irqOut(irqOut));
    core_model core_u (.clk_sys(clk_sys), .rstn(rstn), .irqReq(irqReq), .irqVector(irqVector),
        .fullReq(fullReq), .irqAck(irqAck), .stackFull(stackFull));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        apbReq <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic waitAck();
        for (int n = 0; n < 100 && core_u.seen.size() == 0; n++) @(posedge clk_sys);
        if (core_u.seen.size() == 0) failures++;
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        results();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        for (int a = 0; a <= 20; a += 4) rdChk(8'(a), 32'h0, "reset value");
        apb(1'b1, ADDR_EDGE, 32'h0000_00ff);
        rdChk(ADDR_EDGE, 32'h0000_000f, "edge select");
        apb(1'b1, 8'h18, 32'h0000_0001);
        chk("unmapped error", 32'h1, {31'h0, err});
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            apb(1'b1, i[0] ? ADDR_C2 : ADDR_C1, seed);
            rdChk(i[0] ? ADDR_C2 : ADDR_C1, {24'h0, seed[7:0]}, "ctrl rw");
        end
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_EDGE, 32'(m * 5));
            apb(1'b1, ADDR_C0, 32'h0);
            extIrqPin <= 1'b1;
            rxLine <= 1'b1;
            repeat (8) @(posedge clk_sys);
            chk("poll input", 32'h1, {31'h0, pollIn});
            rdChk(ADDR_C0, 32'(m % 2 * 8'h30), "rise flags");
            apb(1'b1, ADDR_C0, 32'h0);
            extIrqPin <= 1'b0;
            rxLine <= 1'b0;
            repeat (8) @(posedge clk_sys);
            rdChk(ADDR_C0, 32'(m / 2 * 8'h30), "fall flags");
        end
        apb(1'b1, ADDR_C1, 32'h0000_000f);
        apb(1'b1, ADDR_C2, 32'h0000_000f);
        apb(1'b1, ADDR_C0, 32'h0000_000e);
        evt <= '1;
        @(posedge clk_sys);
        evt <= '0;
        for (int i = 2; i < NUM_SRC; i++) expVec.push_back(i);
        repeat (4) @(posedge clk_sys);
        chk("no request without global", 32'h0, {31'h0, irqReq});
        rdChk(ADDR_C0, 32'h0000_004e, "flag without global");
        while (expVec.size() > 0) begin
            // the first write keeps the low-voltage flag that is still waiting
            apb(1'b1, ADDR_C0, (expVec[0] == SRC_LV) ? 32'h0000_004f : 32'h0000_000f);
            waitAck();
            chk("vector", 32'(expVec.pop_front()), 32'(core_u.seen.pop_front()));
            rdChk(ADDR_C0, 32'h0000_000e, "ctrl0 after grant");
        end
        rdChk(ADDR_C1, 32'h0000_000f, "ctrl1 after grants");
        rdChk(ADDR_C2, 32'h0000_000f, "ctrl2 after grants");
        fullReq <= 1'b1;
        apb(1'b1, ADDR_C0, 32'h0000_000f);
        evt <= 9'h001;
        @(posedge clk_sys);
        evt <= '0;
        @(negedge clk_sys);
        chk("wake pulse", 32'h1, {31'h0, wakeReq});
        repeat (5) @(posedge clk_sys);
        chk("held by full stack", 32'h0, {31'h0, irqReq});
        fullReq <= 1'b0;
        waitAck();
        chk("vector after stack", 32'h2, 32'(core_u.seen.pop_front()));
        apb(1'b1, ADDR_MASK, 32'h0000_0003);
        repeat (2) @(posedge clk_sys);
        chk("irq out set", 32'h1, {31'h0, irqOut});
        rdChk(ADDR_STAT, 32'h0000_0003, "status");
        repeat (2) @(posedge clk_sys);
        chk("irq out clear", 32'h0, {31'h0, irqOut});
        results();
    end
endmodule
`default_nettype wire
